// ---- rtl/timer_bank_pkg.sv ----
// Constants, register map and encodings shared by the cascadable timer bank.
package timer_bank_pkg;

    // Byte offsets inside one timer's window.
    localparam logic [4:0] OFF_COUNT = 5'h00;
    localparam logic [4:0] OFF_CMP = 5'h04;
    localparam logic [4:0] OFF_INT = 5'h0c;
    localparam logic [4:0] OFF_CTL = 5'h10;

    // Timer index sits above the 32-byte window of each timer.
    localparam int TMR_SEL_LSB = 5;
    localparam int TMR_SEL_W = 3;

    // Field positions in timer_control, and the clear bit of the interrupt register.
    localparam int CTL_MODE_LO = 0;
    localparam int CTL_PRESCALE_SELECT_LO = 3;
    localparam int CTL_EN = 7;
    localparam int CTL_PRESCALE_SELECT_HI = 8;
    localparam int IRQ_CLR_BIT = 0;

    // Values after reset and on reload, and the count from which the timer wraps.
    localparam logic [31:0] COUNT_RST = 32'h0000_0000;
    localparam logic [31:0] CMP_RST = 32'hffff_ffff;
    localparam logic [31:0] RELOAD_VAL = 32'h0000_0001;
    localparam logic [31:0] COUNT_ALL_ONES = 32'hffff_ffff;

    // Largest prescale exponent: divide by 4096.
    localparam logic [3:0] PRESCALE_SELECT_MAX = 4'hc;
    localparam int PRE_W = 12;

    typedef enum logic [2:0] {
        MODE_ONESHOT = 3'b000,
        MODE_CONT = 3'b001,
        MODE_CASC = 3'b010,
        MODE_COMPARE = 3'b101,
        MODE_AUTOBAUD = 3'b111
    } mode_t;

    typedef enum logic [1:0] {
        AB_WAIT_IDLE = 2'b00,
        AB_WAIT_START = 2'b01,
        AB_START_BIT = 2'b10,
        AB_MEASURE = 2'b11
    } ab_state_t;

endpackage : timer_bank_pkg

// ---- rtl/cascadable_timer_autobaud.sv ----
// Bank of 32-bit reloadable timers with cascade ring and auto-baud measurement.
module cascadable_timer_autobaud #(
    parameter int NT = 5,
    parameter int NU = 3
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // UART receive lines
    input wire logic [NU-1:0] uart_rx_i,
    // Interrupts and cascade taps
    output logic [NT-1:0] irq_o,
    output logic [NT-1:0] cascade_o
);
    import timer_bank_pkg::*;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);

    // Bus side state.
    logic wr_pend_r;
    logic [TMR_SEL_W-1:0] wr_tmr_r;
    logic [4:0] wr_off_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;
    logic [31:0] rd_val;
    logic addr_ok;
    logic rd_take;

    // Per-timer state.
    logic [31:0] count_r [NT];
    logic [31:0] cmp_r [NT];
    logic [2:0] mode_r [NT];
    logic [3:0] prescale_select_r [NT];
    logic [PRE_W-1:0] pre_cnt_r [NT];
    ab_state_t ab_st_r [NT];
    logic [NT-1:0] en_r;
    logic [NT-1:0] irq_r;
    logic [NT-1:0] tout_r;
    logic [NT-1:0] rx_prev_r;
    logic [NT-1:0] rise2_r;

    // Per-timer combinational terms.
    logic [NT-1:0] wr_cnt;
    logic [NT-1:0] wr_cmp;
    logic [NT-1:0] wr_int;
    logic [NT-1:0] wr_ctl;
    logic [NT-1:0] prescale_select_tick;
    logic [NT-1:0] casc_in;
    logic [NT-1:0] step;
    logic [NT-1:0] hit;
    logic [NT-1:0] rx_w;
    logic [NT-1:0] ab_on;
    logic [NT-1:0] ab_ovf;
    logic [NT-1:0] ab_load1;
    logic [NT-1:0] ab_inc;
    logic [NT-1:0] ab_done;

    assign addr_ok = hsel_i && hready_i && htrans_i[1];
    assign rd_take = addr_ok && !hwrite_i;

    // Writes land in the data phase, so hwdata is applied at the edge that ends it.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wr_pend_r <= 1'b0;
            wr_tmr_r <= '0;
            wr_off_r <= '0;
        end else begin
            wr_pend_r <= addr_ok && hwrite_i;
            wr_tmr_r <= haddr_i[TMR_SEL_LSB +: TMR_SEL_W];
            wr_off_r <= haddr_i[4:0];
        end
    end

    // Read data is sampled in the address phase; the read itself has no side effect.
    always_comb begin
        rd_val = '0;
        for (int k = 0; k < NT; k++) begin
            if (haddr_i[TMR_SEL_LSB +: TMR_SEL_W] == TMR_SEL_W'(k)) begin
                case (haddr_i[4:0])
                    OFF_COUNT: rd_val = count_r[k];
                    OFF_CMP: rd_val = cmp_r[k];
                    OFF_INT: rd_val[IRQ_CLR_BIT] = irq_r[k];
                    OFF_CTL: begin
                        rd_val[CTL_EN] = en_r[k];
                        rd_val[CTL_PRESCALE_SELECT_HI] = prescale_select_r[k][3];
                        rd_val[CTL_PRESCALE_SELECT_LO +: 3] = prescale_select_r[k][2:0];
                        rd_val[CTL_MODE_LO +: 3] = mode_r[k];
                    end
                    default: rd_val = '0;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            hrdata_r <= '0;
        end else if (rd_take) begin
            hrdata_r <= rd_val;
        end
    end

    // The slave never waits and never errors; unmapped reads give zero.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    assign hrdata_o = hrdata_r;
    assign hreadyout_o = hreadyout_r;
    assign hresp_o = hresp_r;
    assign irq_o = irq_r;
    assign cascade_o = tout_r;

    for (genvar i = 0; i < NT; i++) begin : g_tmr
        logic [3:0] prescale_select_eff;
        logic [PRE_W-1:0] pre_mask;
        logic sel;
        logic fall;
        logic rise;
        logic cnt_mode;

        assign sel = wr_pend_r && (wr_tmr_r == TMR_SEL_W'(i));
        assign wr_cnt[i] = sel && (wr_off_r == OFF_COUNT);
        assign wr_cmp[i] = sel && (wr_off_r == OFF_CMP);
        assign wr_int[i] = sel && (wr_off_r == OFF_INT);
        assign wr_ctl[i] = sel && (wr_off_r == OFF_CTL);

        // Undefined prescale codes above 12 are held at 12, which divides by 4096.
        assign prescale_select_eff = (prescale_select_r[i] > PRESCALE_SELECT_MAX) ? PRESCALE_SELECT_MAX : prescale_select_r[i];
        assign pre_mask = PRE_W'((13'h1 << prescale_select_eff) - 13'h1);
        assign prescale_select_tick[i] = (pre_cnt_r[i] & pre_mask) == pre_mask;

        // Ring: the last timer wraps back to the first.
        assign casc_in[i] = tout_r[(i + NT - 1) % NT];

        if (i < NU) begin : g_rx
            assign rx_w[i] = uart_rx_i[i];
        end else begin : g_norx
            assign rx_w[i] = 1'b1;
        end

        // Only the four counting modes step here; auto-baud counts through ab_inc, and the other codes leave the timer idle.
        assign cnt_mode = (mode_r[i] == MODE_ONESHOT) || (mode_r[i] == MODE_CONT)
            || (mode_r[i] == MODE_CASC) || (mode_r[i] == MODE_COMPARE);
        assign step[i] = en_r[i] && cnt_mode
            && ((mode_r[i] == MODE_CASC) ? casc_in[i] : prescale_select_tick[i]);
        // A limit of zero is met only after the wrap, giving the full range.
        assign hit[i] = step[i] && (count_r[i] == cmp_r[i]);

        assign fall = rx_prev_r[i] && !rx_w[i];
        assign rise = !rx_prev_r[i] && rx_w[i];
        assign ab_on[i] = en_r[i] && (mode_r[i] == MODE_AUTOBAUD) && (i < NU);
        assign ab_ovf[i] = ab_on[i] && prescale_select_tick[i] && (count_r[i] == cmp_r[i])
            && ((ab_st_r[i] == AB_START_BIT) || (ab_st_r[i] == AB_MEASURE));
        assign ab_done[i] = ab_on[i] && (ab_st_r[i] == AB_MEASURE) && rise && rise2_r[i]
            && !ab_ovf[i];
        assign ab_load1[i] = ab_on[i] && (((ab_st_r[i] == AB_WAIT_START) && fall)
            || ((ab_st_r[i] == AB_START_BIT) && rise) || ab_ovf[i]);
        assign ab_inc[i] = ab_on[i] && prescale_select_tick[i] && !ab_load1[i]
            && ((ab_st_r[i] == AB_START_BIT) || (ab_st_r[i] == AB_MEASURE));

        always_ff @(posedge mclk_i) begin
            if (srst_i) begin
                count_r[i] <= COUNT_RST;
            end else if (wr_cnt[i]) begin
                count_r[i] <= hwdata_i;
            end else if (hit[i] || ab_load1[i]) begin
                count_r[i] <= RELOAD_VAL;
            end else if (step[i] || ab_inc[i]) begin
                count_r[i] <= count_r[i] + 32'h1;
            end
        end

        always_ff @(posedge mclk_i) begin
            if (srst_i) begin
                cmp_r[i] <= CMP_RST;
            end else if (wr_cmp[i]) begin
                cmp_r[i] <= hwdata_i;
            end
        end

        // A software write to control wins over the hardware clear of the enable.
        always_ff @(posedge mclk_i) begin
            if (srst_i) begin
                en_r[i] <= 1'b0;
                mode_r[i] <= MODE_ONESHOT;
                prescale_select_r[i] <= 4'h0;
            end else if (wr_ctl[i]) begin
                en_r[i] <= hwdata_i[CTL_EN];
                mode_r[i] <= hwdata_i[CTL_MODE_LO +: 3];
                prescale_select_r[i] <= {hwdata_i[CTL_PRESCALE_SELECT_HI], hwdata_i[CTL_PRESCALE_SELECT_LO +: 3]};
            end else if ((hit[i] && (mode_r[i] == MODE_ONESHOT)) || ab_done[i]) begin
                en_r[i] <= 1'b0;
            end
        end

        // The prescaler restarts on every enable or control write for a full first period.
        always_ff @(posedge mclk_i) begin
            if (srst_i) begin
                pre_cnt_r[i] <= '0;
            end else if (!en_r[i] || wr_ctl[i]) begin
                pre_cnt_r[i] <= '0;
            end else begin
                pre_cnt_r[i] <= pre_cnt_r[i] + PRE_W'(1);
            end
        end

        // A new event beats a clear arriving in the same cycle.
        always_ff @(posedge mclk_i) begin
            if (srst_i) begin
                irq_r[i] <= 1'b0;
            end else if (hit[i] || ab_done[i]) begin
                irq_r[i] <= 1'b1;
            end else if (wr_int[i] && hwdata_i[IRQ_CLR_BIT]) begin
                irq_r[i] <= 1'b0;
            end
        end

        always_ff @(posedge mclk_i) begin
            if (srst_i) begin
                tout_r[i] <= 1'b0;
            end else begin
                tout_r[i] <= hit[i];
            end
        end

        always_ff @(posedge mclk_i) begin
            if (srst_i) begin
                rx_prev_r[i] <= 1'b1;
            end else begin
                rx_prev_r[i] <= rx_w[i];
            end
        end

        // Auto-baud search; leaving the mode or the enable restarts it from idle.
        always_ff @(posedge mclk_i) begin
            if (srst_i) begin
                ab_st_r[i] <= AB_WAIT_IDLE;
                rise2_r[i] <= 1'b0;
            end else if (!ab_on[i] || wr_ctl[i]) begin
                ab_st_r[i] <= AB_WAIT_IDLE;
                rise2_r[i] <= 1'b0;
            end else begin
                unique case (ab_st_r[i])
                    AB_WAIT_IDLE: begin
                        if (rx_w[i]) begin
                            ab_st_r[i] <= AB_WAIT_START;
                        end
                    end
                    AB_WAIT_START: begin
                        if (fall) begin
                            ab_st_r[i] <= AB_START_BIT;
                        end
                    end
                    AB_START_BIT: begin
                        if (ab_ovf[i]) begin
                            ab_st_r[i] <= AB_WAIT_IDLE;
                        end else if (rise) begin
                            ab_st_r[i] <= AB_MEASURE;
                            rise2_r[i] <= 1'b0;
                        end
                    end
                    AB_MEASURE: begin
                        if (ab_ovf[i] || ab_done[i]) begin
                            ab_st_r[i] <= AB_WAIT_IDLE;
                        end else if (rise) begin
                            rise2_r[i] <= 1'b1;
                        end
                    end
                endcase
            end
        end
        sequence s_oneshot_hit;
            hit[i] && (mode_r[i] == MODE_ONESHOT) && !wr_ctl[i] && !wr_cnt[i];
        endsequence
        sequence s_stopped;
            !en_r[i] && (count_r[i] == RELOAD_VAL) && irq_r[i];
        endsequence
        sequence s_start_end;
            ab_on[i] && (ab_st_r[i] == AB_START_BIT) && !rx_prev_r[i] && rx_w[i]
                && !ab_ovf[i] && !wr_cnt[i] && !wr_ctl[i];
        endsequence

        wrap_to_zero_a: assert property (
            step[i] && !hit[i] && !wr_cnt[i] && (count_r[i] == COUNT_ALL_ONES)
            |=> count_r[i] == COUNT_RST)
            else $error("count did not wrap to zero");

        prescale_gap_a: assert property (
            prescale_select_tick[i] && en_r[i] && (prescale_select_r[i] == 4'h2) && !wr_ctl[i]
            |=> !prescale_select_tick[i] ##1 !prescale_select_tick[i] ##1 !prescale_select_tick[i])
            else $error("prescale by four ticked early");

        oneshot_stop_a: assert property (
            s_oneshot_hit |=> s_stopped)
            else $error("one-shot did not stop and reload");

        periodic_reload_a: assert property (
            hit[i] && (mode_r[i] != MODE_ONESHOT) && !wr_ctl[i] && !wr_cnt[i]
            |=> en_r[i] && (count_r[i] == RELOAD_VAL) && irq_r[i])
            else $error("periodic timer did not reload and continue");

        cascade_step_a: assert property (
            en_r[i] && (mode_r[i] == MODE_CASC) && !hit[i] && !wr_cnt[i] && !wr_ctl[i]
            |=> count_r[i] == $past(count_r[i]) + {31'h0, $past(casc_in[i])})
            else $error("cascade timer stepped without a cascade pulse");

        timeout_pulse_a: assert property (
            hit[i] |=> cascade_o[i] && casc_in[(i + 1) % NT])
            else $error("timeout did not reach the next timer");

        irq_sticky_a: assert property (
            irq_r[i] && !(wr_int[i] && hwdata_i[IRQ_CLR_BIT]) |=> irq_o[i])
            else $error("interrupt dropped without a clear");

        irq_clear_a: assert property (
            wr_int[i] && hwdata_i[IRQ_CLR_BIT] && !hit[i] && !ab_done[i] |=> !irq_o[i])
            else $error("interrupt clear had no effect");

        freeze_count_a: assert property (
            !en_r[i] && !wr_cnt[i] |=> $stable(count_r[i]))
            else $error("count moved while disabled");

        count_load_a: assert property (
            wr_cnt[i] |=> count_r[i] == $past(hwdata_i))
            else $error("written count not loaded at the next edge");

        ab_preset_a: assert property (
            s_start_end |=> (count_r[i] == RELOAD_VAL) && (ab_st_r[i] == AB_MEASURE))
            else $error("measurement did not restart from one");

        ab_done_a: assert property (
            ab_done[i] && !wr_ctl[i] && !wr_cnt[i] |=> !en_r[i] && irq_r[i]
            && (count_r[i] == $past(count_r[i]) + {31'h0, $past(prescale_select_tick[i])}))
            else $error("auto-baud completion did not clear the enable");

        ab_overflow_a: assert property (
            ab_ovf[i] && !wr_ctl[i] |=> (ab_st_r[i] == AB_WAIT_IDLE))
            else $error("auto-baud overflow did not restart the search");

        ab_idle_first_a: assert property (
            ab_on[i] && (ab_st_r[i] == AB_WAIT_IDLE) && !wr_cnt[i]
            |=> (ab_st_r[i] != AB_START_BIT) && $stable(count_r[i]))
            else $error("auto-baud counted before the line went idle");
    end
    read_live_a: assert property (
        rd_take && (haddr_i[4:0] == OFF_COUNT) && (haddr_i[TMR_SEL_LSB +: TMR_SEL_W] == 3'h0)
        |=> hrdata_o == $past(count_r[0]))
        else $error("count read did not return the live value");
endmodule : cascadable_timer_autobaud

// ---- verification/uart_line_model.sv ----
// Behavioural UART transmitter that drives one receive line of the timer bank.
module uart_line_model (
    // Clock
    input wire logic mclk_i,
    // Serial line toward the timer
    output logic rx_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // The line starts low, as if a break were in progress, so the idle search is exercised.
    initial rx_o = 1'b0;

    task automatic hold_line(input logic lvl, input int cycles);
        rx_o <= lvl;
        repeat (cycles) @(posedge mclk_i);
    endtask : hold_line

    // One start bit, eight data bits with the least significant first, one stop bit.
    task automatic send_char(input logic [7:0] ch, input int bit_cycles);
        hold_line(1'b0, bit_cycles);
        for (int i = 0; i < 8; i++) begin
            hold_line(ch[i], bit_cycles);
        end
        hold_line(1'b1, bit_cycles);
    endtask : send_char
endmodule : uart_line_model

// ---- verification/cascadable_timer_autobaud_tb_top.sv ----
// Self-checking testbench for the cascadable timer bank with auto-baud measurement.
module cascadable_timer_autobaud_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import timer_bank_pkg::*;

    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic hresp_o;
    logic [4:0] irq_o;
    logic [4:0] cascade_o;
    logic rx_line;
    int fail_count = 0;
    int compares = 0;

    cascadable_timer_autobaud #(.NT(5), .NU(3)) cascadable_timer_autobaud_i (
        .mclk_i(mclk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'b010), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .uart_rx_i({2'b11, rx_line}), .irq_o(irq_o), .cascade_o(cascade_o)
    );

    uart_line_model uart_line_model_i (.mclk_i(mclk_i), .rx_o(rx_line));

    always #5 mclk_i = ~mclk_i;

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic check_range(input string what, input logic [31:0] lo, input logic [31:0] hi,
                               input logic [31:0] got);
        compares++;
        if ($isunknown(got) || got < lo || got > hi) begin
            fail_count++;
            $display("MISMATCH %s expected %h..%h seen %h", what, lo, hi, got);
        end
    endtask : check_range

    function automatic logic [31:0] ctl_val(input logic [2:0] mode, input logic [3:0] prescale_select,
                                            input logic en);
        logic [31:0] v;
        v = 32'h0;
        v[CTL_MODE_LO +: 3] = mode;
        v[CTL_PRESCALE_SELECT_LO +: 3] = prescale_select[2:0];
        v[CTL_PRESCALE_SELECT_HI] = prescale_select[3];
        v[CTL_EN] = en;
        return v;
    endfunction : ctl_val

    // One single AHB-Lite transfer; entered and left just after a rising edge.
    task automatic bus(input logic wr, input int k, input logic [4:0] off, input logic [31:0] d,
                       output logic [31:0] rd);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, k[2:0], off};
        htrans_i <= 2'b10;
        hwrite_i <= wr;
        @(posedge mclk_i);
        while (hreadyout_o !== 1'b1) @(posedge mclk_i);
        htrans_i <= 2'b00;
        hwdata_i <= d;
        @(posedge mclk_i);
        while (hreadyout_o !== 1'b1) @(posedge mclk_i);
        rd = hrdata_o;
    endtask : bus

    // Program one timer with the enable cleared first and set last.
    task automatic setup(input int k, input logic [2:0] mode, input logic [3:0] prescale_select,
                         input logic [31:0] cnt, input logic [31:0] lim);
        logic [31:0] rd;
        bus(1'b1, k, OFF_CTL, ctl_val(mode, prescale_select, 1'b0), rd);
        bus(1'b1, k, OFF_COUNT, cnt, rd);
        bus(1'b1, k, OFF_CMP, lim, rd);
        bus(1'b1, k, OFF_CTL, ctl_val(mode, prescale_select, 1'b1), rd);
    endtask : setup

    // Outputs are sampled on the falling edge, where registered values have settled.
    task automatic wait_irq(input int k, input int lim, output int n);
        n = 0;
        while (irq_o[k] !== 1'b1 && n < lim) begin
            @(negedge mclk_i);
            n++;
        end
        check("irq_wait", 32'h1, {31'h0, irq_o[k]});
        @(posedge mclk_i);
    endtask : wait_irq

    task automatic pulse_gap(input int k, output int w, output int g);
        int n;
        n = 0;
        while (cascade_o[k] !== 1'b1 && n < 300) begin
            @(negedge mclk_i);
            n++;
        end
        w = 0;
        while (cascade_o[k] === 1'b1 && w < 300) begin
            @(negedge mclk_i);
            w++;
        end
        g = w;
        while (cascade_o[k] !== 1'b1 && g < 300) begin
            @(negedge mclk_i);
            g++;
        end
        @(posedge mclk_i);
    endtask : pulse_gap

    task automatic t_reset_vals;
        logic [31:0] rd;
        bus(1'b0, 0, OFF_COUNT, 32'h0, rd);
        check("count_rst", COUNT_RST, rd);
        bus(1'b0, 0, OFF_CMP, 32'h0, rd);
        check("limit_rst", CMP_RST, rd);
        bus(1'b0, 0, OFF_CTL, 32'h0, rd);
        check("ctl_rst", 32'h0, rd);
        bus(1'b0, 5, OFF_CMP, 32'h0, rd);
        check("unmapped_read", 32'h0, rd);
        check("resp_okay", 32'h0, {31'h0, hresp_o});
    endtask : t_reset_vals

    task automatic t_one_shot;
        logic [31:0] rd;
        int n;
        setup(1, MODE_ONESHOT, 4'h0, 32'h5, 32'h8);
        wait_irq(1, 50, n);
        repeat (20) @(posedge mclk_i);
        bus(1'b0, 1, OFF_COUNT, 32'h0, rd);
        check("oneshot_count", RELOAD_VAL, rd);
        bus(1'b0, 1, OFF_CTL, 32'h0, rd);
        check("oneshot_ctl", ctl_val(MODE_ONESHOT, 4'h0, 1'b0), rd);
        bus(1'b1, 1, OFF_INT, 32'h0, rd);
        @(negedge mclk_i);
        check("irq_held", 32'h1, {31'h0, irq_o[1]});
        @(posedge mclk_i);
        bus(1'b1, 1, OFF_INT, 32'h1, rd);
        bus(1'b0, 1, OFF_INT, 32'h0, rd);
        check("irq_cleared", 32'h0, rd);
    endtask : t_one_shot

    // Timer 4 heads the chain; timer 0 with limit two times out on every second head pulse.
    task automatic t_cascade_ring;
        logic [31:0] rd;
        int w;
        int g;
        setup(0, MODE_CASC, 4'h5, 32'h0, 32'h2);
        setup(1, MODE_CASC, 4'h0, 32'h0, 32'h1);
        setup(4, MODE_CONT, 4'h1, 32'h1, 32'h3);
        pulse_gap(4, w, g);
        check("head_width", 32'd1, w);
        check("head_period", 32'd6, g);
        pulse_gap(0, w, g);
        check("ring_width", 32'd1, w);
        check("ring_period", 32'd12, g);
        wait_irq(1, 100, w);
        check("ring_irq", 32'h1, {31'h0, irq_o[0]});
        bus(1'b1, 4, OFF_CTL, ctl_val(MODE_CONT, 4'h1, 1'b0), rd);
    endtask : t_cascade_ring

    task automatic t_compare;
        logic [31:0] a;
        logic [31:0] b;
        int n;
        setup(2, MODE_COMPARE, 4'h0, 32'hffff_fffe, 32'h3);
        wait_irq(2, 20, n);
        bus(1'b0, 2, OFF_CTL, 32'h0, a);
        check("compare_ctl", ctl_val(MODE_COMPARE, 4'h0, 1'b1), a);
        bus(1'b1, 2, OFF_CMP, COUNT_ALL_ONES, a);
        bus(1'b1, 2, OFF_COUNT, 32'h100, a);
        bus(1'b0, 2, OFF_COUNT, 32'h0, a);
        check_range("live_load", 32'h100, 32'h103, a);
        bus(1'b0, 2, OFF_COUNT, 32'h0, b);
        check("live_read", a + 32'd2, b);
        bus(1'b1, 2, OFF_CTL, ctl_val(MODE_COMPARE, 4'h0, 1'b0), a);
        bus(1'b0, 2, OFF_COUNT, 32'h0, a);
        repeat (10) @(posedge mclk_i);
        bus(1'b0, 2, OFF_COUNT, 32'h0, b);
        check("frozen", a, b);
    endtask : t_compare

    // Limit one from zero needs two ticks, so the time-out is twice the division ratio.
    task automatic t_prescale(input logic [3:0] p, input int exp);
        logic [31:0] rd;
        int n;
        setup(3, MODE_COMPARE, p, 32'h0, 32'h1);
        wait_irq(3, exp + 20, n);
        check_range("prescale_time", exp - 2, exp + 2, n);
        bus(1'b1, 3, OFF_CTL, ctl_val(MODE_COMPARE, p, 1'b0), rd);
        bus(1'b1, 3, OFF_INT, 32'h1, rd);
    endtask : t_prescale

    task automatic t_autobaud;
        logic [31:0] rd;
        int n;
        bus(1'b1, 0, OFF_INT, 32'h1, rd);
        setup(0, MODE_AUTOBAUD, 4'h0, 32'h0, 32'd1000);
        uart_line_model_i.hold_line(1'b0, 50);
        uart_line_model_i.hold_line(1'b1, 30);
        uart_line_model_i.hold_line(1'b0, 1200);
        bus(1'b0, 0, OFF_CTL, 32'h0, rd);
        check("break_keeps_en", ctl_val(MODE_AUTOBAUD, 4'h0, 1'b1), rd);
        uart_line_model_i.hold_line(1'b1, 30);
        uart_line_model_i.send_char(8'h0d, 20);
        wait_irq(0, 50, n);
        bus(1'b0, 0, OFF_COUNT, 32'h0, rd);
        // Both edges are seen one clock late, so the span is exact and the preset adds one.
        check("char_count", 32'd161, rd);
        bus(1'b0, 0, OFF_CTL, 32'h0, rd);
        check("ab_en_cleared", ctl_val(MODE_AUTOBAUD, 4'h0, 1'b0), rd);
    endtask : t_autobaud

    initial begin
        repeat (5) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(posedge mclk_i);
        t_reset_vals();
        t_one_shot();
        t_cascade_ring();
        t_compare();
        t_prescale(4'h0, 2);
        t_prescale(4'h2, 8);
        t_prescale(4'hc, 8192);
        t_autobaud();
        test_done();
    end

    // The longest scenario runs about 8200 cycles; the rest add under two thousand more.
    initial begin
        #300000;
        fail_count++;
        $display("MISMATCH watchdog expected finish seen timeout");
        test_done();
    end
endmodule : cascadable_timer_autobaud_tb_top
